/* tpm_core.sv */
/*
 * tpm_core: port data/direction, test register, run control in stop, wait,
 * debug and disabled states, and the free-running and accumulator counters.
 * Assumes an APB master, pins sampled synchronously, and the prescaler,
 * compare and capture logic outside supplying ticks and compare levels.
 */
`timescale 1ns/1ns
// Overview of operation
// - test register writes accepted only while special-mode-low input is low
// - timer bypass splits free counter into 8-bit halves, skips prescaler
// - accumulator bypass splits its counter into 8-bit halves, skips prescaler
// - data read returns pin level for inputs, driver level for outputs
// - data writes go to a latch, reaching pins only when outputs
// - data writes do not change pins driven by output compare
// - direction bit zero means input, one means output
// - enabled output compare forces output, direction bit kept as stored
// - disabled output compare returns direction to its register bit
// - enabled input capture never overrides the direction bit
// - stop mode leaves the timer inactive
// - debug mode keeps counting unless halt-in-debug is one
// - wait mode keeps counters running unless halt-in-wait is set
// - normal operation runs unless timer enable is zero
// - timer disable stops all timer work and the divide-by-64 clock
// - accumulator disable stops accumulator work, registers stay reachable
module tpm_core #(
	parameter int PORT_W = 8
) (
	input  wire logic              pclk,             // bus clock, 25 MHz
	input  wire logic              presetn,          // async reset, active low
	input  wire logic              psel,             // apb select
	input  wire logic              penable,          // apb access phase
	input  wire logic              pwrite,           // apb direction
	input  wire logic [7:0]        paddr,            // apb byte address
	input  wire logic [31:0]       pwdata,           // apb write data
	output logic                   pready,           // apb ready
	output logic      [31:0]       prdata,           // apb read data
	output logic                   pslverr,          // apb error, unmapped
	input  wire logic              special_mode_low, // low in special mode
	input  wire logic              stop_mode,        // clocks halted
	input  wire logic              wait_mode,        // cpu wait state
	input  wire logic              background_debug_state, // debug mode active
	input  wire logic              prescale_tick,    // timer prescaler strobe
	input  wire logic              accum_event,      // synchronised accumulator event
	input  wire logic              accum_gate,       // gated mode selected
	input  wire logic [PORT_W-1:0] oc_level,         // output compare pin levels
	input  wire logic [PORT_W-1:0] pin_in,           // sampled pin levels
	output logic      [PORT_W-1:0] pin_out,          // pin drive value
	output logic      [PORT_W-1:0] pin_oe_n,         // drive enable, low drives
	output logic                   timer_running,    // timer counting
	output logic                   accum_running,    // accumulator counting
	output logic                   div64_tick,       // gated accumulation clock
	output logic      [15:0]       timer_count       // free-running counter
);
	initial begin
		if (PORT_W < 1 || PORT_W > 8) begin
			$error("tpm_core: PORT_W must be 1 to 8");
		end
	end

	logic [PORT_W-1:0] data_ff, dir_ff, ocen_ff;
	logic [1:0]        test_ff;
	logic [3:0]        mode_ff;
	logic [5:0]        div_ff;
	logic [PORT_W-1:0] pin_out_ff, pin_oe_n_ff;
	logic              pready_ff, pslverr_ff, trun_ff, arun_ff, div64_ff;
	logic [31:0]       prdata_ff;
	tpm_pkg::tpm_run_t run_ff;
	tpm_pkg::tpm_run_t nxt_run;
	logic [15:0]       acc_count, tmr_count;

	// apb decode; one wait state so read data comes from a flop
	wire setup    = psel & ~penable;
	wire access_w = psel & penable & pwrite & ~pready_ff;
	wire hit_cnt  = paddr == tpm_pkg::ADDR_COUNT;
	wire hit_test = paddr == tpm_pkg::ADDR_TEST;
	wire hit_data = paddr == tpm_pkg::ADDR_DATA;
	wire hit_dir  = paddr == tpm_pkg::ADDR_DIR;
	wire hit_mode = paddr == tpm_pkg::ADDR_MODE;
	wire hit_ocen = paddr == tpm_pkg::ADDR_OCEN;
	wire hit_tcnt = paddr == tpm_pkg::ADDR_TCOUNT;
	wire mapped   = hit_cnt | hit_test | hit_data | hit_dir | hit_mode | hit_ocen | hit_tcnt;
	wire wr_ok    = access_w & mapped;
	wire wr_cnt   = wr_ok & hit_cnt;                        // whole-word load
	wire wr_test  = wr_ok & hit_test & ~special_mode_low;

	// mode bits
	wire timer_run_enable       = mode_ff[tpm_pkg::MODE_TIMER_EN_BIT];
	wire accumulator_run_enable = mode_ff[tpm_pkg::MODE_ACCUM_EN_BIT];
	wire halt_in_wait           = mode_ff[tpm_pkg::MODE_WAIT_HALT_BIT];
	wire halt_in_debug          = mode_ff[tpm_pkg::MODE_DEBUG_HALT_BIT];
	wire timer_chain_bypass     = test_ff[tpm_pkg::TEST_TIMER_BYP_BIT];
	wire accum_chain_bypass     = test_ff[tpm_pkg::TEST_ACCUM_BYP_BIT];

	// halt conditions; stop wins because both clocks are gone there
	wire halted = stop_mode
		| (background_debug_state & halt_in_debug)
		| (wait_mode & halt_in_wait);
	wire t_run  = timer_run_enable & ~halted;
	wire a_run  = accumulator_run_enable & ~halted;

	always_comb begin
		nxt_run = run_ff;
		case (run_ff)
			tpm_pkg::tpm_off_st:  nxt_run = t_run ? tpm_pkg::tpm_run_st :
				(timer_run_enable ? tpm_pkg::tpm_halt_st : tpm_pkg::tpm_off_st);
			tpm_pkg::tpm_run_st:  nxt_run = !timer_run_enable ? tpm_pkg::tpm_off_st :
				(halted ? tpm_pkg::tpm_halt_st : tpm_pkg::tpm_run_st);
			tpm_pkg::tpm_halt_st: nxt_run = !timer_run_enable ? tpm_pkg::tpm_off_st :
				(halted ? tpm_pkg::tpm_halt_st : tpm_pkg::tpm_run_st);
			default:              nxt_run = tpm_pkg::tpm_off_st;
		endcase
	end
	wire run_now = run_ff == tpm_pkg::tpm_run_st;

	// divide-by-64 clock comes from the timer chain, dead when timer is off
	wire div_step = run_now & prescale_tick;
	wire div_wrap = div_step & (div_ff == tpm_pkg::DIV64_MAX);
	wire [5:0] nxt_div = run_now ? (div_step ? div_ff + 6'h01 : div_ff) : 6'h00;

	// accumulator counts events, or divided clock while gated
	wire acc_tick = accum_gate ? (div_wrap & accum_event) : accum_event;

	// pin direction: compare forces output, capture has no say
	wire [PORT_W-1:0] is_out  = dir_ff | ocen_ff;
	wire [PORT_W-1:0] drive_v = (ocen_ff & oc_level) | (~ocen_ff & data_ff);
	// read view: pin for inputs, driver input for outputs
	wire [PORT_W-1:0] data_rd = (is_out & drive_v) | (~is_out & pin_in);
	wire [PORT_W-1:0] wdat    = pwdata[PORT_W-1:0];

	wire [31:0] rd_mux =
		hit_cnt  ? {16'h0000, acc_count} :
		hit_test ? {30'h00000000, test_ff} :
		hit_data ? {{(32-PORT_W){1'b0}}, data_rd} :
		hit_dir  ? {{(32-PORT_W){1'b0}}, dir_ff} :
		hit_mode ? {28'h0000000, mode_ff} :
		hit_ocen ? {{(32-PORT_W){1'b0}}, ocen_ff} :
		hit_tcnt ? {16'h0000, tmr_count} : 32'h00000000;

	// free-running timer counter
	tpm_split_counter #(.WIDTH(16)) u_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (run_now),
		.tick     (prescale_tick),
		.bypass   (timer_chain_bypass),
		.load     (1'b0),
		.load_val (16'h0000),
		.count    (tmr_count)
	);

	// pulse accumulator counter; registers stay writable while stopped
	tpm_split_counter #(.WIDTH(16)) u_accum (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (a_run),
		.tick     (acc_tick),
		.bypass   (accum_chain_bypass),
		.load     (wr_cnt),
		.load_val (pwdata[15:0]),
		.count    (acc_count)
	);

	// software registers; data writes go only to the data latch, never the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_ff <= '0;
			dir_ff  <= '0;
			ocen_ff <= '0;
			mode_ff <= 4'h0;
		end else begin
			if (wr_ok & hit_data) data_ff <= wdat;
			if (wr_ok & hit_dir)  dir_ff  <= wdat;
			if (wr_ok & hit_ocen) ocen_ff <= wdat;
			if (wr_ok & hit_mode) mode_ff <= pwdata[3:0];
		end
	end

	// test register guarded by special mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_ff <= 2'h0;
		end else if (wr_test) begin
			test_ff <= pwdata[1:0];
		end
	end

	// run state and divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_ff   <= tpm_pkg::tpm_off_st;
			div_ff   <= 6'h00;
			div64_ff <= 1'b0;
		end else begin
			run_ff   <= nxt_run;
			div_ff   <= nxt_div;
			div64_ff <= div_wrap;
		end
	end

	// apb answer, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else begin
			pready_ff  <= psel & penable & ~pready_ff;
			pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
			if (psel & penable & ~pready_ff & ~pwrite) prdata_ff <= rd_mux;
		end
	end

	// registered pin and status outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out_ff  <= '0;
			pin_oe_n_ff <= '1;
			trun_ff     <= 1'b0;
			arun_ff     <= 1'b0;
		end else begin
			pin_out_ff  <= drive_v;
			pin_oe_n_ff <= ~is_out;
			trun_ff     <= t_run;
			arun_ff     <= a_run;
		end
	end

	assign pready        = pready_ff;
	assign pslverr       = pslverr_ff;
	assign prdata        = prdata_ff;
	assign pin_out       = pin_out_ff;
	assign pin_oe_n      = pin_oe_n_ff;
	assign timer_running = trun_ff;
	assign accum_running = arun_ff;
	assign div64_tick    = div64_ff;
	// counters are flops inside the counter module
	assign timer_count   = tmr_count;

	// assertions
	sequence s_test_write;
		psel & penable & pwrite & ~pready_ff & hit_test;
	endsequence

	test_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
		(s_test_write and special_mode_low) |=> $stable(test_ff))
		else $error("test register changed outside special mode");
	test_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(s_test_write and !special_mode_low) |=> test_ff == $past(pwdata[1:0]))
		else $error("test register write lost in special mode");
	oc_force_a: assert property (@(posedge pclk) disable iff (!presetn)
		ocen_ff[0] |=> !pin_oe_n[0])
		else $error("enabled compare pin not driven");
	dir_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ocen_ff[0] |=> pin_oe_n[0] == !$past(dir_ff[0]))
		else $error("pin direction ignores direction bit");
	oc_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		ocen_ff[0] |=> pin_out[0] == $past(oc_level[0]))
		else $error("data write reached a compare pin");
	data_view_a: assert property (@(posedge pclk) disable iff (!presetn)
		!is_out[0] |-> data_rd[0] == pin_in[0])
		else $error("input pin read does not show pin level");
	// three samples needed: the run state lags its inputs by one edge, the count by one more
	sequence s_stop_held;
		stop_mode ##1 stop_mode ##1 stop_mode;
	endsequence
	sequence s_enable_low;
		!timer_run_enable ##1 !timer_run_enable ##1 !timer_run_enable;
	endsequence

	stop_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_stop_held |-> $stable(tmr_count) && !timer_running)
		else $error("timer moved in stop mode");
	enable_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_enable_low |-> !div64_tick && $stable(tmr_count))
		else $error("timer or divided clock alive while disabled");
	accum_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!accumulator_run_enable && !wr_cnt) ##1 !accumulator_run_enable |-> $stable(acc_count))
		else $error("accumulator moved while disabled");
	dbg_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		(background_debug_state && halt_in_debug) |=> !timer_running)
		else $error("timer running in debug with halt set");
	wait_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wait_mode && halt_in_wait) |=> !timer_running)
		else $error("timer running in wait with halt set");
	run_normal_a: assert property (@(posedge pclk) disable iff (!presetn)
		(timer_run_enable && !stop_mode && !wait_mode && !background_debug_state) |=> timer_running)
		else $error("enabled timer not running");
	bypass_split_a: assert property (@(posedge pclk) disable iff (!presetn)
		(timer_chain_bypass && run_now) |=> tmr_count[15:8] == $past(tmr_count[15:8]) + 8'h01)
		else $error("bypass upper half not stepping");
	bypass_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(timer_chain_bypass && run_now) |=> tmr_count[7:0] == $past(tmr_count[7:0]) + 8'h01)
		else $error("bypass lower half not stepping");
	abyp_split_a: assert property (@(posedge pclk) disable iff (!presetn)
		(accum_chain_bypass && a_run && !wr_cnt) |=> acc_count[7:0] == $past(acc_count[7:0]) + 8'h01)
		else $error("accumulator bypass lower half not stepping");
	count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!run_now |=> $stable(tmr_count))
		else $error("timer counter moved while not running");
	div_dead_a: assert property (@(posedge pclk) disable iff (!presetn)
		!run_now |=> div_ff == 6'h00 && !div64_tick)
		else $error("divided clock alive with timer stopped");
	wait_run_a: assert property (@(posedge pclk) disable iff (!presetn)
		(timer_run_enable && wait_mode && !halt_in_wait && !stop_mode
			&& !(background_debug_state && halt_in_debug)) |=> timer_running)
		else $error("timer stopped in wait without halt bit");
	dbg_run_a: assert property (@(posedge pclk) disable iff (!presetn)
		(timer_run_enable && background_debug_state && !halt_in_debug && !stop_mode
			&& !(wait_mode && halt_in_wait)) |=> timer_running)
		else $error("timer stopped in debug without halt bit");
	accum_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		!accumulator_run_enable |=> !accum_running)
		else $error("accumulator shown running while disabled");
	accum_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		(accumulator_run_enable && !halted) |=> accum_running)
		else $error("enabled accumulator not running");

	// whole-word load of the count, and the latch and direction behaviour of pin 0
	count_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_cnt |=> acc_count == $past(pwdata[15:0]))
		else $error("count word not loaded whole");
	pin_input_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!dir_ff[0] && !ocen_ff[0]) |=> pin_oe_n[0])
		else $error("input pin driven");
	pin_output_a: assert property (@(posedge pclk) disable iff (!presetn)
		dir_ff[0] |=> !pin_oe_n[0])
		else $error("output pin not driven");
	data_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		(dir_ff[0] && !ocen_ff[0]) |=> pin_out[0] == $past(data_ff[0]))
		else $error("output pin does not show data latch");
	dir_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ocen_ff[0] && !(wr_ok && hit_dir)) |=> $stable(dir_ff))
		else $error("direction bits changed by compare enable");
	out_view_a: assert property (@(posedge pclk) disable iff (!presetn)
		(dir_ff[0] && !ocen_ff[0]) |-> data_rd[0] == data_ff[0])
		else $error("output pin read does not show driver level");

	// bus answer: one wait state, ready for one cycle, error only with ready
	apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup |=> !pready)
		else $error("ready raised in the setup cycle");
	apb_once_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held longer than one cycle");
	apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error shown without ready");
endmodule // tpm_core

/* tpm_pkg.sv */
/*
 * tpm_pkg: register map, field positions, reset values and states shared by
 * the timer port and mode control block.
 * Assumes an APB slave with 32-bit data, one aligned word per register.
 */
package tpm_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_COUNT   = 8'h00; // pulse_count_value
	localparam logic [7:0] ADDR_TEST    = 8'h04; // timer_test_control
	localparam logic [7:0] ADDR_DATA    = 8'h08; // timer_port_data
	localparam logic [7:0] ADDR_DIR     = 8'h0c; // timer_port_direction
	localparam logic [7:0] ADDR_MODE    = 8'h10; // run enables and halt bits
	localparam logic [7:0] ADDR_OCEN    = 8'h14; // output compare enable per pin
	localparam logic [7:0] ADDR_TCOUNT  = 8'h18; // free-running counter, read only
	// test register fields
	localparam int TEST_TIMER_BYP_BIT  = 1;
	localparam int TEST_ACCUM_BYP_BIT  = 0;
	// mode register fields
	localparam int MODE_TIMER_EN_BIT   = 0;
	localparam int MODE_ACCUM_EN_BIT   = 1;
	localparam int MODE_WAIT_HALT_BIT  = 2;
	localparam int MODE_DEBUG_HALT_BIT = 3;
	// reset values
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [15:0] RST_WORD  = 16'h0000;
	// divide ratio of the gated accumulation clock
	localparam logic [5:0]  DIV64_MAX = 6'h3f;
	// run state of the timer
	typedef enum logic [1:0] {tpm_off_st, tpm_run_st, tpm_halt_st} tpm_run_t;
endpackage

/* tpm_split_counter.sv */
/*
 * tpm_split_counter: 16-bit counter that can be split into two independent
 * 8-bit halves, each stepping on every bus clock cycle, ignoring the tick, when the chain is bypassed.
 * Assumes a synchronous load port driven by the register file.
 */
`timescale 1ns/1ns
module tpm_split_counter #(
	parameter int WIDTH = 16
) (
	input  wire logic             pclk,     // bus clock
	input  wire logic             presetn,  // async reset, active low
	input  wire logic             run,      // counter allowed to move
	input  wire logic             tick,     // prescaled count strobe
	input  wire logic             bypass,   // split into halves, skip prescaler
	input  wire logic             load,     // software write strobe
	input  wire logic [WIDTH-1:0] load_val, // value to load
	output logic      [WIDTH-1:0] count     // current count
);
	localparam int HALF = WIDTH / 2;
	initial begin
		if (WIDTH < 2 || (WIDTH % 2) != 0) begin
			$error("tpm_split_counter: WIDTH must be even and at least 2");
		end
	end

	logic [WIDTH-1:0] count_ff;
	logic [WIDTH-1:0] nxt_count;
	wire              step     = run & (bypass | tick);
	wire [HALF-1:0]   lo_inc   = count_ff[HALF-1:0] + {{(HALF-1){1'b0}}, 1'b1};
	wire [HALF-1:0]   hi_inc   = count_ff[WIDTH-1:HALF] + {{(HALF-1){1'b0}}, 1'b1};
	wire              lo_wrap  = &count_ff[HALF-1:0];
	// halves run independently in bypass, upper half carries otherwise
	wire              hi_step  = bypass | lo_wrap;

	assign nxt_count = load ? load_val :
		!step ? count_ff :
		{(hi_step ? hi_inc : count_ff[WIDTH-1:HALF]), lo_inc};

	// counter register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end
	assign count = count_ff;
endmodule // tpm_split_counter

/* tpm_pin_model.sv */
/*
 * tpm_pin_model: pins outside the timer port plus the accumulator event source.
 * Assumes the bench sets the external levels and asks for event pulses.
 */
`timescale 1ns/1ns
module tpm_pin_model (
	input  wire logic       pclk,        // bus clock
	input  wire logic [7:0] pin_out,     // drive value from the block
	input  wire logic [7:0] pin_oe_n,    // low drives the pin
	input  wire logic [7:0] ext_level,   // level of the outside source
	input  wire logic       pulse_req,   // ask for one accumulator pulse
	output logic      [7:0] pin_in,      // resolved pin level
	output logic            accum_event  // accumulator event line
);
	logic [1:0] width_ff = 2'h0;
	// wire level from both drivers; the outside only drives undriven pins
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
	// stretch each pulse to three cycles, wider than the synchroniser window
	always_ff @(posedge pclk) begin
		if (pulse_req) width_ff <= 2'h3;
		else if (width_ff != 2'h0) width_ff <= width_ff - 2'h1;
	end
	assign accum_event = (width_ff != 2'h0);
endmodule // tpm_pin_model

/* tb.sv */
/*
 * tb: directed bench for tpm_core, registers through apb, pins through the model.
 * Assumes 25 MHz pclk and any number of wait states per apb transfer.
 */
`timescale 1ns/1ns
module tb;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, oc_level = 8'h00, ext_level = 8'h00, pin_in, pin_out, pin_oe_n;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, smode_low = 1'b1, stop_m = 1'b0, wait_m = 1'b0, dbg = 1'b0;
	logic        tick = 1'b0, gate = 1'b0, pulse_req = 1'b0, accum_event, t_run, a_run, d64;
	logic [15:0] tcount, c0;
	int          err_total = 0, n_tests = 0, n_div = 0;
	always #20 pclk = ~pclk;
	tpm_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.special_mode_low(smode_low), .stop_mode(stop_m), .wait_mode(wait_m),
		.background_debug_state(dbg), .prescale_tick(tick), .accum_event(accum_event),
		.accum_gate(gate), .oc_level(oc_level), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .timer_running(t_run), .accum_running(a_run), .div64_tick(d64),
		.timer_count(tcount));
	tpm_pin_model pin_u (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
		.pulse_req(pulse_req), .pin_in(pin_in), .accum_event(accum_event));
	// count gated accumulation strobes for the disable checks
	always @(posedge pclk) if (d64 === 1'b1) n_div <= n_div + 1;
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task test_done;
		if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// one apb transfer, request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait count assumed; only the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	// let register effects land, then look mid-cycle
	task settle;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
	endtask
	task t_reset_map;
		for (int i = 0; i < 7; i++) rchk(8'(i * 4), 32'h0);
		rchk(8'h1c, 32'h0);
		check(er, 1'b1); // unmapped place answers with an error
		check(pin_oe_n, 8'hff);
	endtask
	task t_test_reg;
		apb(1'b1, tpm_pkg::ADDR_TEST, 32'h3);
		rchk(tpm_pkg::ADDR_TEST, 32'h0);
		smode_low <= 1'b0;
		apb(1'b1, tpm_pkg::ADDR_TEST, 32'h3);
		smode_low <= 1'b1;
		rchk(tpm_pkg::ADDR_TEST, 32'h3);
		apb(1'b1, tpm_pkg::ADDR_TEST, 32'h0);
		rchk(tpm_pkg::ADDR_TEST, 32'h3);
		// clear both bypasses so later counts use the normal chains
		smode_low <= 1'b0;
		apb(1'b1, tpm_pkg::ADDR_TEST, 32'h0);
		smode_low <= 1'b1;
		rchk(tpm_pkg::ADDR_TEST, 32'h0);
	endtask
	task t_port;
		ext_level <= 8'h3c;
		apb(1'b1, tpm_pkg::ADDR_DATA, 32'ha5);
		settle;
		check(pin_oe_n, 8'hff);
		apb(1'b1, tpm_pkg::ADDR_DIR, 32'h0f);
		settle;
		check(pin_oe_n, 8'hf0);
		check(pin_out[3:0], 4'h5);
		rchk(tpm_pkg::ADDR_DATA, 32'h35);
		oc_level <= 8'h81;
		apb(1'b1, tpm_pkg::ADDR_OCEN, 32'h81);
		apb(1'b1, tpm_pkg::ADDR_DATA, 32'h00);
		settle;
		check(pin_oe_n, 8'h70);
		check({pin_out[7], pin_out[0]}, 2'b11);
		rchk(tpm_pkg::ADDR_DIR, 32'h0f);
		apb(1'b1, tpm_pkg::ADDR_OCEN, 32'h00);
		settle;
		check(pin_oe_n, 8'hf0);
		check(pin_out[0], 1'b0);
	endtask
	task t_modes;
		@(posedge pclk);
		tick <= 1'b1;
		apb(1'b1, tpm_pkg::ADDR_MODE, 32'h0d);
		settle;
		check(t_run, 1'b1);
		@(posedge pclk);
		wait_m <= 1'b1;
		settle;
		check(t_run, 1'b0);
		@(posedge pclk);
		wait_m <= 1'b0; dbg <= 1'b1;
		settle;
		check(t_run, 1'b0);
		apb(1'b1, tpm_pkg::ADDR_MODE, 32'h01);
		wait_m <= 1'b1;
		settle;
		check(t_run, 1'b1);
		@(posedge pclk);
		wait_m <= 1'b0; dbg <= 1'b0; stop_m <= 1'b1;
		settle;
		check(t_run, 1'b0);
		@(posedge pclk);
		stop_m <= 1'b0;
		settle;
		c0 = tcount;
		settle;
		check(tcount != c0, 1'b1);
	endtask
	task t_disable;
		@(posedge pclk);
		gate <= 1'b1;
		apb(1'b1, tpm_pkg::ADDR_MODE, 32'h03);
		n_div = 0;
		repeat (140) @(posedge pclk);
		check(n_div > 0, 1'b1);
		apb(1'b1, tpm_pkg::ADDR_MODE, 32'h02);
		settle;
		n_div = 0;
		c0 = tcount;
		repeat (140) @(posedge pclk);
		check(n_div, 0);
		check(tcount, c0);
		check(t_run, 1'b0);
		rchk(tpm_pkg::ADDR_DIR, 32'h0f);
		gate <= 1'b0;
	endtask
	task t_accum;
		apb(1'b1, tpm_pkg::ADDR_COUNT, 32'h1234);
		rchk(tpm_pkg::ADDR_COUNT, 32'h1234);
		pulse_req <= 1'b1;
		@(posedge pclk);
		pulse_req <= 1'b0;
		repeat (6) @(posedge pclk);
		apb(1'b0, tpm_pkg::ADDR_COUNT, 32'h0);
		check(rd != 32'h1234, 1'b1);
		apb(1'b1, tpm_pkg::ADDR_MODE, 32'h00);
		apb(1'b1, tpm_pkg::ADDR_COUNT, 32'h00ff);
		pulse_req <= 1'b1;
		@(posedge pclk);
		pulse_req <= 1'b0;
		repeat (6) @(posedge pclk);
		check(a_run, 1'b0);
		rchk(tpm_pkg::ADDR_COUNT, 32'h00ff);
	endtask
	task t_bypass;
		tick <= 1'b0;
		smode_low <= 1'b0;
		apb(1'b1, tpm_pkg::ADDR_MODE, 32'h01);
		apb(1'b1, tpm_pkg::ADDR_TEST, 32'h2);
		settle;
		c0 = tcount;
		repeat (10) @(negedge pclk);
		check(8'(tcount[7:0] - c0[7:0]), 8'h0a);
		check(8'(tcount[15:8] - c0[15:8]), 8'h0a);
		apb(1'b1, tpm_pkg::ADDR_MODE, 32'h02);
		apb(1'b1, tpm_pkg::ADDR_TEST, 32'h1);
		apb(1'b0, tpm_pkg::ADDR_COUNT, 32'h0);
		c0 = rd[15:0];
		apb(1'b0, tpm_pkg::ADDR_COUNT, 32'h0);
		check(rd[7:0] != c0[7:0] && rd[15:8] != c0[15:8], 1'b1);
	endtask
	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		test_done;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_map;
		t_test_reg;
		t_port;
		t_modes;
		t_disable;
		t_accum;
		t_bypass;
		test_done;
	end
endmodule // tb
